// >>> common/spmsp_consts.svh
// Purpose: Constants for the serial master/slave port, both ends
// Assumes: Included by bare name
// Notes:   Register offsets are for the user-side register port of spmsp_port; the partner end has none
`ifndef SPMSP_CONSTS_SVH
`define SPMSP_CONSTS_SVH

// User register offsets (4-bit address)
`define SPMSP_ADDR_CTRL    4'h0
`define SPMSP_ADDR_DATA    4'h1
`define SPMSP_ADDR_STATUS  4'h2
`define SPMSP_ADDR_IRQ_EN  4'h3
`define SPMSP_ADDR_IRQ_CLR 4'h4

// Control field positions
`define SPMSP_CTRL_ENABLE  0
`define SPMSP_CTRL_MASTER  1
`define SPMSP_CTRL_LSB     2
`define SPMSP_CTRL_DIR_OE  3
`define SPMSP_CTRL_SS_LVL  4
`define SPMSP_CTRL_RATE_LO 5
`define SPMSP_CTRL_RATE_HI 7
`define SPMSP_CTRL_PWR_OFF 8
`define SPMSP_CTRL_RESET   9'h100

// Status / interrupt bit positions
`define SPMSP_ST_DONE      0
`define SPMSP_ST_OVERRUN   1
`define SPMSP_ST_BUSY      2

// Bits per transfer
`define SPMSP_BITS         4'h8

`endif

// >>> common/spmsp_pkg.sv
// Purpose: Types shared by both ends of the serial port
// Assumes: Constants live in spmsp_consts.svh
// Notes:   Rate codes give system clocks per full serial period
package spmsp_pkg;
  typedef enum logic [2:0] {
    SPMSP_RATE_DIV2,
    SPMSP_RATE_DIV4,
    SPMSP_RATE_DIV8,
    SPMSP_RATE_DIV16,
    SPMSP_RATE_DIV32,
    SPMSP_RATE_DIV64,
    SPMSP_RATE_DIV128
  } spmsp_rate_t;

  typedef enum logic [1:0] {
    SPMSP_IDLE,
    SPMSP_LEAD,
    SPMSP_TRAIL
  } spmsp_state_t;
endpackage

// >>> common/spmsp_if.sv
// Purpose: Serial link between the port under design and its partner
// Assumes: Every line has one driver with an enable; bench resolves levels
// Notes:   Partner end is a master driving sck, mosi and ss_n
`timescale 1ns/1ps
interface spmsp_if;
  logic sck_o;      // Port drives clock when master
  logic sck_oe;
  logic mosi_o;
  logic mosi_oe;
  logic miso_o;     // Port drives when slave and selected
  logic miso_oe;
  logic ss_n_o;
  logic ss_n_oe;
  logic p_sck;      // Partner drives these
  logic p_mosi;
  logic p_ss_n;
  logic p_miso;
  logic p_miso_oe;
  logic sck;        // Resolved wire levels, set by the bench
  logic mosi;
  logic miso;
  logic ss_n;

  modport port (
    output sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe,
    input  sck, mosi, miso, ss_n
  );
  modport partner (
    output p_sck, p_mosi, p_ss_n, p_miso, p_miso_oe,
    input  sck, mosi, miso, ss_n
  );
endinterface

// >>> hdl/spmsp_port.sv
// Purpose: Byte-wide full-duplex serial port, master or slave role
// Assumes: rst asynchronous active high; link inputs come from pins
// Notes:   Mode 0 timing: sample on rising sck, shift on falling sck
`timescale 1ns/1ps
`include "spmsp_consts.svh"
module spmsp_port (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [8:0] rdata,
  output logic            irq,
  spmsp_if.port           lnk
);
  logic [8:0]  ctrl_q;
  logic [7:0]  shift_q;
  logic [7:0]  rx_buf_q;
  logic [3:0]  bit_cnt_q;
  logic [6:0]  div_q;
  logic [2:0]  status_q;
  logic [2:0]  irq_en_q;
  logic [2:0]  sck_sy_q, mosi_sy_q, miso_sy_q, ss_sy_q;
  logic        sck_prev_q;
  logic        sck_out_q;
  logic        in_bit_q;
  spmsp_pkg::spmsp_state_t state_q;

  // Decoded controls; power-off bit idles both engines and all pin enables
  wire active  = ctrl_q[`SPMSP_CTRL_ENABLE] & ~ctrl_q[`SPMSP_CTRL_PWR_OFF];
  wire master  = ctrl_q[`SPMSP_CTRL_MASTER];
  wire lsb     = ctrl_q[`SPMSP_CTRL_LSB];
  wire sck_s   = sck_sy_q[1];
  wire ss_s    = ss_sy_q[1];
  wire sel     = active & ~master & ~ss_s;
  wire rise    = sel & sck_s & ~sck_prev_q;
  wire fall    = sel & ~sck_s & sck_prev_q;
  wire busy    = (state_q != spmsp_pkg::SPMSP_IDLE) | (sel & (bit_cnt_q != 4'h0));
  wire dwrite  = wr & (addr == `SPMSP_ADDR_DATA);
  wire tick    = (div_q == 7'h00);

  // Half-period reload value per rate code: length in system clocks minus one
  function automatic logic [6:0] half_len(input logic [2:0] code);
    half_len = 7'(7'h01 << code) - 7'h01;
  endfunction

  // Next bit to present on the data output
  function automatic logic out_bit(input logic [7:0] s, input logic l);
    out_bit = l ? s[0] : s[7];
  endfunction

  // Shift one received bit in, in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic l,
                                          input logic b);
    shift_in = l ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // Pin synchronisers; stage 0 only feeds stage 1
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sck_sy_q  <= 3'h0;
      mosi_sy_q <= 3'h0;
      miso_sy_q <= 3'h0;
      ss_sy_q   <= 3'h7;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_sy_q  <= {sck_sy_q[1:0], lnk.sck};
      mosi_sy_q <= {mosi_sy_q[1:0], lnk.mosi};
      miso_sy_q <= {miso_sy_q[1:0], lnk.miso};
      ss_sy_q   <= {ss_sy_q[1:0], lnk.ss_n};
      sck_prev_q <= sck_sy_q[1];
    end
  end

  // Control and enable registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q   <= `SPMSP_CTRL_RESET;
      irq_en_q <= 3'h0;
    end
    else if (wr & (addr == `SPMSP_ADDR_CTRL))
      ctrl_q <= {(wdata[0] ? ctrl_q[8] : ctrl_q[8]), wdata};
    else if (wr & (addr == `SPMSP_ADDR_STATUS))
      ctrl_q[`SPMSP_CTRL_PWR_OFF] <= wdata[0];  // Power gate lives here
    else if (wr & (addr == `SPMSP_ADDR_IRQ_EN))
      irq_en_q <= wdata[2:0];
  end

  // Master clock generator and both shift engines
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= spmsp_pkg::SPMSP_IDLE;
      shift_q   <= 8'h00;
      bit_cnt_q <= 4'h0;
      div_q     <= 7'h00;
      sck_out_q <= 1'b0;
      in_bit_q  <= 1'b0;
    end
    else if (!active)
    begin
      state_q   <= spmsp_pkg::SPMSP_IDLE;
      bit_cnt_q <= 4'h0;
      sck_out_q <= 1'b0;
      if (dwrite)
        shift_q <= wdata;
    end
    else if (master)
    begin
      unique case (state_q)
        spmsp_pkg::SPMSP_IDLE:
        begin
          if (dwrite)
          begin
            shift_q   <= wdata;
            bit_cnt_q <= 4'h0;
            div_q     <= half_len(ctrl_q[`SPMSP_CTRL_RATE_HI:`SPMSP_CTRL_RATE_LO]);
            state_q   <= spmsp_pkg::SPMSP_LEAD;
          end
        end
        spmsp_pkg::SPMSP_LEAD:
        begin
          div_q <= tick ? half_len(ctrl_q[`SPMSP_CTRL_RATE_HI:`SPMSP_CTRL_RATE_LO])
                        : div_q - 7'h01;
          if (tick)  // Rising edge: sample partner data
          begin
            sck_out_q <= 1'b1;
            in_bit_q  <= miso_sy_q[1];
            state_q   <= spmsp_pkg::SPMSP_TRAIL;
          end
        end
        spmsp_pkg::SPMSP_TRAIL:
        begin
          div_q <= tick ? half_len(ctrl_q[`SPMSP_CTRL_RATE_HI:`SPMSP_CTRL_RATE_LO])
                        : div_q - 7'h01;
          if (tick)  // Falling edge: shift
          begin
            sck_out_q <= 1'b0;
            shift_q   <= shift_in(shift_q, lsb, in_bit_q);
            bit_cnt_q <= bit_cnt_q + 4'h1;
            state_q   <= (bit_cnt_q == `SPMSP_BITS - 4'h1) ? spmsp_pkg::SPMSP_IDLE
                                                          : spmsp_pkg::SPMSP_LEAD;
          end
        end
        default: state_q <= spmsp_pkg::SPMSP_IDLE;
      endcase
    end
    else
    begin
      // Slave role: deselect discards partial byte, edges ignored
      if (ss_s)
      begin
        bit_cnt_q <= 4'h0;
        if (dwrite)
          shift_q <= wdata;
      end
      else if (rise)
        in_bit_q <= mosi_sy_q[1];
      else if (fall)
      begin
        shift_q   <= shift_in(shift_q, lsb, in_bit_q);
        bit_cnt_q <= (bit_cnt_q == `SPMSP_BITS - 4'h1) ? 4'h0 : bit_cnt_q + 4'h1;
      end
      else if (dwrite & (bit_cnt_q == 4'h0))
        shift_q <= wdata;
    end
  end

  // Byte-complete event for both roles
  wire done = active & ((master & (state_q == spmsp_pkg::SPMSP_TRAIL) & tick
                         & (bit_cnt_q == `SPMSP_BITS - 4'h1))
                        | (fall & (bit_cnt_q == `SPMSP_BITS - 4'h1)));
  wire [7:0] rx_next = shift_in(shift_q, lsb, in_bit_q);

  // Receive buffer; each byte overwrites it, flagged as overrun while done is still set
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rx_buf_q <= 8'h00;
    else if (done)
      rx_buf_q <= rx_next;
  end

  // Sticky status; set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      status_q <= 3'h0;
    else
    begin
      status_q[`SPMSP_ST_DONE] <= done
        | (status_q[`SPMSP_ST_DONE] & ~(wr & (addr == `SPMSP_ADDR_IRQ_CLR) & wdata[0]));
      status_q[`SPMSP_ST_OVERRUN] <= (done & status_q[`SPMSP_ST_DONE])
        | (status_q[`SPMSP_ST_OVERRUN] & ~(wr & (addr == `SPMSP_ADDR_IRQ_CLR) & wdata[1]));
      status_q[`SPMSP_ST_BUSY] <= busy
        | (status_q[`SPMSP_ST_BUSY] & ~(wr & (addr == `SPMSP_ADDR_IRQ_CLR) & wdata[2]));
    end
  end

  // Read data one cycle after the strobe; data read returns receive buffer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata <= 9'h000;
    else if (rd)
      unique case (addr)
        `SPMSP_ADDR_CTRL:   rdata <= ctrl_q;
        `SPMSP_ADDR_DATA:   rdata <= {1'b0, rx_buf_q};
        `SPMSP_ADDR_STATUS: rdata <= {6'h00, status_q};
        `SPMSP_ADDR_IRQ_EN: rdata <= {6'h00, irq_en_q};
        default:            rdata <= 9'h000;
      endcase
    else
      rdata <= 9'h000;
  end

  // Level interrupt from enabled sticky bits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status_q & irq_en_q);
  end

  // Pin overrides by role; select level is software's only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lnk.sck_o   <= 1'b0;
      lnk.sck_oe  <= 1'b0;
      lnk.mosi_o  <= 1'b0;
      lnk.mosi_oe <= 1'b0;
      lnk.miso_o  <= 1'b0;
      lnk.miso_oe <= 1'b0;
      lnk.ss_n_o  <= 1'b1;
      lnk.ss_n_oe <= 1'b0;
    end
    else
    begin
      lnk.sck_o   <= sck_out_q;
      lnk.sck_oe  <= active & master & ctrl_q[`SPMSP_CTRL_DIR_OE];
      lnk.mosi_o  <= out_bit(shift_q, lsb);
      lnk.mosi_oe <= active & master & ctrl_q[`SPMSP_CTRL_DIR_OE];
      lnk.miso_o  <= out_bit(shift_q, lsb);
      lnk.miso_oe <= sel & ctrl_q[`SPMSP_CTRL_DIR_OE];
      lnk.ss_n_o  <= ctrl_q[`SPMSP_CTRL_SS_LVL];
      lnk.ss_n_oe <= active & master & ctrl_q[`SPMSP_CTRL_DIR_OE];
    end
  end
endmodule

// >>> hdl/spmsp_partner.sv
// Purpose: Partner end: external master driving select, clock and data
// Assumes: Software loads a byte and pulses start; clock from a divider
// Notes:   Keeps sck at a quarter of clk_sys or slower
`timescale 1ns/1ps
`include "spmsp_consts.svh"
module spmsp_partner #(
  parameter logic [7:0] HALF_CLKS = 8'h08  // also covers the port's miso lag
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] tx_byte,
  input  wire logic       start,
  input  wire logic       last,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            busy,
  spmsp_if.partner        lnk
);
  logic [7:0] sh_q, cnt_q;
  logic [3:0] bits_q;
  logic [1:0] miso_sy_q;
  logic       keep_q;
  logic       rel_q;
  spmsp_pkg::spmsp_state_t st_q;

  // Two-stage capture of the port's data output
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      miso_sy_q <= 2'h0;
    else
      miso_sy_q <= {miso_sy_q[0], lnk.miso};
  end

  // Master sequence: select low, eight pulses, then reload or release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= spmsp_pkg::SPMSP_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      bits_q <= 4'h0;
      keep_q <= 1'b0;
      rel_q <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      busy <= 1'b0;
      lnk.p_sck <= 1'b0;
      lnk.p_mosi <= 1'b0;
      lnk.p_ss_n <= 1'b1;
      lnk.p_miso <= 1'b0;
      lnk.p_miso_oe <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      unique case (st_q)
        spmsp_pkg::SPMSP_IDLE:
          // Select held one more half period, else the slave drops its last bit
          if (rel_q)
          begin
            if (cnt_q == 8'h00)
            begin
              rx_valid <= 1'b1;
              busy <= 1'b0;
              rel_q <= 1'b0;
              lnk.p_ss_n <= ~keep_q;
            end
            else
              cnt_q <= cnt_q - 8'h01;
          end
          else if (start)
          begin
            sh_q <= tx_byte;
            keep_q <= ~last;
            lnk.p_ss_n <= 1'b0;
            lnk.p_mosi <= tx_byte[7];
            busy <= 1'b1;
            cnt_q <= HALF_CLKS;
            bits_q <= 4'h0;
            st_q <= spmsp_pkg::SPMSP_LEAD;
          end
        spmsp_pkg::SPMSP_LEAD:
          if (cnt_q == 8'h00)
          begin
            lnk.p_sck <= 1'b1;
            sh_q <= {sh_q[6:0], miso_sy_q[1]};
            cnt_q <= HALF_CLKS;
            st_q <= spmsp_pkg::SPMSP_TRAIL;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        spmsp_pkg::SPMSP_TRAIL:
          if (cnt_q == 8'h00)
          begin
            lnk.p_sck <= 1'b0;
            lnk.p_mosi <= sh_q[7];
            bits_q <= bits_q + 4'h1;
            cnt_q <= HALF_CLKS;
            if (bits_q == `SPMSP_BITS - 4'h1)
            begin
              rx_byte <= sh_q;
              rel_q <= 1'b1;
              st_q <= spmsp_pkg::SPMSP_IDLE;
            end
            else
              st_q <= spmsp_pkg::SPMSP_LEAD;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        default: st_q <= spmsp_pkg::SPMSP_IDLE;
      endcase
    end
  end
endmodule

// >>> testbench/spmsp_properties.sv
// Purpose: Link-level properties for the serial port pair
// Assumes: Inputs are interface lines, sampled on clk_sys
// Notes:   Select checks allow for the port's input synchroniser
`timescale 1ns/1ps
module spmsp_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_o,
  input wire logic mosi_oe,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic ss_n_o,
  input wire logic ss_n_oe,
  input wire logic p_sck,
  input wire logic p_mosi,
  input wire logic p_ss_n,
  input wire logic sck,
  input wire logic ss_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Slave output stays off while deselected
  AST_MISO_OFF_DESEL: assert property (ss_n [*4] |-> !miso_oe)
    else $error("miso driven while deselected");
  AST_MISO_RELEASE: assert property ($rose(ss_n) |-> ##[1:4] !miso_oe)
    else $error("miso not released after select rise");
  // Pin directions follow the role
  AST_MASTER_MISO_IN: assert property (sck_oe |-> !miso_oe)
    else $error("master drives miso");
  AST_SLAVE_PINS_IN: assert property (miso_oe |-> !(sck_oe || mosi_oe || ss_n_oe))
    else $error("slave drives an input pin");
  // Data is stable on the sampling edge of every clock pulse
  AST_MOSI_SETUP: assert property (sck_oe && $rose(sck_o) |-> $stable(mosi_o))
    else $error("mosi moved at sck rise");
  AST_MISO_SETUP: assert property (miso_oe && !ss_n && $rose(sck) |-> $stable(miso_o))
    else $error("miso moved at sck rise");
  AST_PMOSI_SETUP: assert property (!p_ss_n && $rose(p_sck) |-> $stable(p_mosi))
    else $error("partner mosi moved at sck rise");
  // Select only moves with the clock parked low
  AST_SS_QUIET: assert property (sck_oe && $changed(ss_n_o) |-> !sck_o)
    else $error("select moved during a clock pulse");
  // Partner halves last two clocks or more, so a quarter rate at most
  AST_PSCK_HIGH: assert property ($rose(p_sck) |=> p_sck)
    else $error("partner sck high too short");
  AST_PSCK_LOW: assert property ($fell(p_sck) |=> !p_sck)
    else $error("partner sck low too short");
endmodule

// >>> testbench/tb_top.sv
// Purpose: Port as slave to the partner, then as master at every rate
// Assumes: Partner sends MSB first; miso idles low when undriven
// Notes:   Register tasks start on a rising edge and end just after one
`timescale 1ns/1ps
`include "spmsp_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  logic       clk_sys;
  logic       rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [8:0] rdata;
  logic       irq;
  logic [7:0] tx_byte;
  logic       start;
  logic       last;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       busy;
  logic [8:0] v;
  logic [7:0] prx;
  logic [7:0] bits;
  logic       prev;
  int         err_total;
  int         checks_done;
  int         cyc;
  int         n;
  int         rises;
  int         tick;

  spmsp_if lnk ();
  // Whoever raises its enable owns the line
  assign lnk.sck  = lnk.sck_oe ? lnk.sck_o : lnk.p_sck;
  assign lnk.mosi = lnk.mosi_oe ? lnk.mosi_o : lnk.p_mosi;
  assign lnk.ss_n = lnk.ss_n_oe ? lnk.ss_n_o : lnk.p_ss_n;
  assign lnk.miso = lnk.miso_oe ? lnk.miso_o : 1'b0;

  spmsp_port i_spmsp_port (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .lnk(lnk.port));
  spmsp_partner #(.HALF_CLKS(8'h08)) i_spmsp_partner (.clk_sys(clk_sys), .rst(rst),
    .tx_byte(tx_byte), .start(start), .last(last), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .busy(busy), .lnk(lnk.partner));
  spmsp_properties i_spmsp_properties (.clk_sys(clk_sys), .rst(rst), .sck_o(lnk.sck_o),
    .sck_oe(lnk.sck_oe), .mosi_o(lnk.mosi_o), .mosi_oe(lnk.mosi_oe), .miso_o(lnk.miso_o),
    .miso_oe(lnk.miso_oe), .ss_n_o(lnk.ss_n_o), .ss_n_oe(lnk.ss_n_oe), .p_sck(lnk.p_sck),
    .p_mosi(lnk.p_mosi), .p_ss_n(lnk.p_ss_n), .sck(lnk.sck), .ss_n(lnk.ss_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Idle edge after the strobe keeps two strobes from merging
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [8:0] q);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  // Partner sends one byte and closes the packet
  task automatic p_xfer(input logic [7:0] b);
    @(posedge clk_sys);
    tx_byte <= b;
    last    <= 1'b1;
    start   <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    for (n = 0; n < 400 && rx_valid !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    prx = rx_byte;
  endtask

  task automatic wait_irq();
    for (n = 0; n < 200 && irq !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_sys)
  begin
    tick++;
    if (tick == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    {addr, wdata, wr, rd, tx_byte, start, last} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(`SPMSP_ADDR_CTRL, v); `CHK(v, 9'h100)
    wr_reg(`SPMSP_ADDR_CTRL, 8'h09);
    p_xfer(8'h3c); `CHK(busy, 1'b0)
    rd_reg(`SPMSP_ADDR_STATUS, v); `CHK(v[0], 1'b0)
    wr_reg(`SPMSP_ADDR_STATUS, 8'h00);
    rd_reg(`SPMSP_ADDR_CTRL, v); `CHK(v, 9'h009)
    wr_reg(`SPMSP_ADDR_IRQ_EN, 8'h03);
    wr_reg(`SPMSP_ADDR_DATA, 8'ha5);
    p_xfer(8'h3c); `CHK(prx, 8'ha5)
    wait_irq(); `CHK(irq, 1'b1)
    rd_reg(`SPMSP_ADDR_STATUS, v); `CHK(v[1:0], 2'b01)
    rd_reg(`SPMSP_ADDR_DATA, v); `CHK(v, 9'h03c)
    wr_reg(`SPMSP_ADDR_IRQ_CLR, 8'h01);
    rd_reg(`SPMSP_ADDR_STATUS, v); `CHK(irq, 1'b0)
    wr_reg(`SPMSP_ADDR_DATA, 8'h5a);
    p_xfer(8'h11); `CHK(prx, 8'h5a)
    wait_irq();
    // Byte 0x11 left unread and flagged, so the next one overruns it
    p_xfer(8'h22);
    wait_irq();
    rd_reg(`SPMSP_ADDR_STATUS, v); `CHK(v[1:0], 2'b11)
    rd_reg(`SPMSP_ADDR_DATA, v); `CHK(v, 9'h022)
    wr_reg(`SPMSP_ADDR_IRQ_CLR, 8'h03);
    wr_reg(`SPMSP_ADDR_CTRL, 8'h0d);
    wr_reg(`SPMSP_ADDR_DATA, 8'h01);
    p_xfer(8'h03); `CHK(prx, 8'h80)
    wait_irq();
    rd_reg(`SPMSP_ADDR_DATA, v); `CHK(v, 9'h0c0)
    wr_reg(`SPMSP_ADDR_IRQ_CLR, 8'h03);
    // Master at each rate; a second write lands mid-byte and must be dropped
    for (int k = 0; k < 7; k++)
    begin
      wr_reg(`SPMSP_ADDR_CTRL, {3'(k), 5'h0b});
      @(posedge clk_sys);
      addr  <= `SPMSP_ADDR_DATA;
      wdata <= 8'hc3 ^ 8'(k);
      wr    <= 1'b1;
      {bits, prev, rises, cyc} = '0;
      while (irq !== 1'b1 && cyc < 3000)
      begin
        @(posedge clk_sys);
        cyc++;
        if (cyc == 1 || cyc == 5)
          wr <= 1'b0;
        if (cyc == 4)
        begin
          wr    <= 1'b1;
          wdata <= 8'hff;
        end
        #1;
        if (lnk.sck_o === 1'b1 && prev === 1'b0)
        begin
          bits = {bits[6:0], lnk.mosi};
          rises++;
        end
        prev = lnk.sck_o;
      end
      `CHK(bits, 8'hc3 ^ 8'(k))
      `CHK(rises == 8, 1'b1)
      `CHK(cyc >= (16 << k) && cyc <= (16 << k) + 5, 1'b1)
      `CHK(lnk.ss_n, 1'b0)
      wr_reg(`SPMSP_ADDR_IRQ_CLR, 8'h01);
      rd_reg(`SPMSP_ADDR_DATA, v); `CHK(v, 9'h000)
    end
    final_report();
  end
endmodule
